/* File: sram_link_pkg.sv */
// Shared constants and types for the burst-of-two separate-port SRAM link.
package sram_link_pkg;

   // -------------------------------------------------------------
   // Widths and timing
   // -------------------------------------------------------------
   localparam int DATA_W             = 18;
   localparam int LANE_W             = 9;
   localparam int LOC_W              = 8;
   localparam int IMP_W              = 5;
   localparam int CLK_PERIOD_NS      = 20;
   localparam int LINK_PERIOD_NS     = 160;
   localparam int LINK_PERIOD_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int K_HALF_CYCLES      = LINK_PERIOD_CYCLES / 2;
   localparam int CAL_START_CYCLES   = 32768;
   localparam int CAL_PERIOD_CYCLES  = 1024;

   // -------------------------------------------------------------
   // Reset values, host phase points and beat selects
   // -------------------------------------------------------------
   localparam logic [IMP_W-1:0] IMP_RESET = 5'h10;
   localparam logic [2:0]       PH_CMD    = 3'h6;
   localparam logic [2:0]       PH_BEAT1  = 3'h2;
   localparam logic [2:0]       PH_ARM    = 3'h4;
   localparam logic             BEAT0     = 1'h0;
   localparam logic             BEAT1     = 1'h1;

   // Host read tracking states.
   typedef enum logic [4:0] {
      RD_IDLE  = 5'b00001,
      RD_SENT  = 5'b00010,
      RD_WAIT  = 5'b00100,
      RD_ARMED = 5'b01000,
      RD_BEAT1 = 5'b10000
   } rd_state_e;

endpackage : sram_link_pkg

/* File: sram_link_if.sv */
// Pin bundle between the memory controller and the SRAM port.
`timescale 1ns/1ps
interface sram_link_if #(
   parameter int DATA_W = sram_link_pkg::DATA_W,
   parameter int LOC_W  = sram_link_pkg::LOC_W,
   parameter int LANES  = DATA_W / sram_link_pkg::LANE_W
);
   logic              k;
   logic              k_n;
   logic              c;
   logic              c_n;
   logic              store_request_n;
   logic              fetch_enable_n;
   logic [LOC_W-1:0]  location_inputs;
   logic [LANES-1:0]  lane_mask_n;
   logic [DATA_W-1:0] d;
   logic [DATA_W-1:0] q;
   logic              q_oe;
   logic              returned_output_strobe;
   logic              returned_output_strobe_n;

   modport device (
      input  k, k_n, c, c_n, store_request_n, fetch_enable_n, location_inputs, lane_mask_n, d,
      output q, q_oe, returned_output_strobe, returned_output_strobe_n
   );
   modport host (
      output k, k_n, c, c_n, store_request_n, fetch_enable_n, location_inputs, lane_mask_n, d,
      input  q, q_oe, returned_output_strobe, returned_output_strobe_n
   );
endinterface : sram_link_if

/* File: pair_buffer.sv */
// Small valid/ready FIFO that holds returned read words.
`timescale 1ns/1ps
module pair_buffer #(
   parameter int W     = 36,
   parameter int DEPTH = 2
)(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] slot;
      logic [PW-1:0]           wp;
      logic [PW-1:0]           rp;
      logic [CW-1:0]           cnt;
   } buf_s;

   buf_s r;
   buf_s next_r;
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready  = (r.cnt != CW'(DEPTH));
   assign out_valid = (r.cnt != '0);
   assign out_data  = r.slot[r.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointers wrap at the depth; a push and pop together keep the count.
   always_comb
   begin
      next_r = r;
      if (push)
      begin
         next_r.slot[r.wp] = in_data;
         next_r.wp         = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
      end
      if (pop)
      begin
         next_r.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
      end
      next_r.cnt = r.cnt + CW'(push) - CW'(pop);
   end

   // State register with synchronous reset.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end
endmodule : pair_buffer

/* File: sram_port_device.sv */
// SRAM end of the link: write and read ports, output firing and impedance sequencing.
`timescale 1ns/1ps
module sram_port_device #(
   parameter int DATA_W     = sram_link_pkg::DATA_W,
   parameter int LOC_W      = sram_link_pkg::LOC_W,
   parameter int IMP_W      = sram_link_pkg::IMP_W,
   parameter int CAL_START  = sram_link_pkg::CAL_START_CYCLES,
   parameter int CAL_PERIOD = sram_link_pkg::CAL_PERIOD_CYCLES
)(
   input  wire logic             clk,
   input  wire logic             nrst,
   sram_link_if.device           link,
   input  wire logic [IMP_W-1:0] impedance_set_pin,
   output logic [IMP_W-1:0]      pd_code,
   output logic [IMP_W-1:0]      pu_code,
   output logic                  imped_ready
);
   localparam int LANES = DATA_W / sram_link_pkg::LANE_W;
   localparam int PIN_W = 6 + LOC_W + LANES + DATA_W;
   localparam int P_M   = DATA_W;
   localparam int P_L   = P_M + LANES;
   localparam int P_RD  = P_L + LOC_W;
   localparam int P_WR  = P_RD + 1;
   localparam int P_CK  = P_WR + 1;
   localparam int CNT_W = $clog2(CAL_START + 1);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      logic [PIN_W-1:0]  s1;
      logic [PIN_W-1:0]  s2;
      logic [PIN_W-1:0]  s3;
      logic [3:0]        ck_lvl;     // Agreed levels of k, k_n, c, c_n.
      logic              wr_go;
      logic [DATA_W-1:0] wd0;
      logic [LANES-1:0]  wm0;
      logic              wr_commit;
      logic [LOC_W-1:0]  wloc;
      logic [DATA_W-1:0] wd1;
      logic [LANES-1:0]  wm1;
      logic              rd_pend;
      logic [LOC_W-1:0]  rloc_pend;
      logic              rd_armed;
      logic [LOC_W-1:0]  rloc;
      logic [DATA_W-1:0] q;
      logic [DATA_W-1:0] q_hold;
      logic              q_oe;
      logic              ros;
      logic              ros_n;
      logic [CNT_W-1:0]  start_cnt;
      logic              ready;
      logic [CNT_W-1:0]  cal_cnt;
      logic              pd_pend;
      logic              pu_pend;
      logic [IMP_W-1:0]  pd;
      logic [IMP_W-1:0]  pu;
   } dev_s;

   dev_s              r;
   dev_s              next_r;
   logic [DATA_W-1:0] mem [2**(LOC_W+1)];
   logic [PIN_W-1:0]  pins;
   logic [3:0]        ck_s3;
   logic [3:0]        agree;
   logic [3:0]        rise;
   logic              k_rise;
   logic              kn_rise;
   logic              use_k;
   logic              fire_lvl;
   logic              firen_lvl;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Expands active-low lane masks into a per-bit store enable.
   function automatic logic [DATA_W-1:0] lane_en(input logic [LANES-1:0] mask_n);
      logic [DATA_W-1:0] en;
      en = '0;
      for (int i = 0; i < LANES; i++)
      begin
         en[i*sram_link_pkg::LANE_W +: sram_link_pkg::LANE_W] = {sram_link_pkg::LANE_W{~mask_n[i]}};
      end
      return en;
   endfunction : lane_en

   // Moves a drive code one step toward the wanted code.
   function automatic logic [IMP_W-1:0] step_toward(input logic [IMP_W-1:0] cur,
                                                    input logic [IMP_W-1:0] want);
      if (cur < want)
      begin
         return cur + 1'b1;
      end
      else if (cur > want)
      begin
         return cur - 1'b1;
      end
      return cur;
   endfunction : step_toward

   // -------------------------------------------------------------
   // Pin sampling and clock edge recovery
   // -------------------------------------------------------------
   // All link pins share one three-stage sampler so data stays aligned with the strobes.
   assign pins   = {link.k, link.k_n, link.c, link.c_n, link.store_request_n, link.fetch_enable_n,
                    link.location_inputs, link.lane_mask_n, link.d};
   assign ck_s3  = r.s3[P_CK +: 4];
   assign agree  = ~(r.s2[P_CK +: 4] ^ ck_s3);
   assign rise   = agree & ck_s3 & ~r.ck_lvl;
   assign k_rise = rise[3];
   assign kn_rise = rise[2];
   // Output clocks both held high hand firing back to the input strobes.
   assign use_k     = r.ck_lvl[1] & r.ck_lvl[0];
   assign fire_lvl  = use_k ? r.ck_lvl[3] : r.ck_lvl[1];
   assign firen_lvl = use_k ? r.ck_lvl[2] : r.ck_lvl[0];

   // -------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------
   always_comb
   begin
      next_r        = r;
      next_r.s1     = pins;
      next_r.s2     = r.s1;
      next_r.s3     = r.s2;
      next_r.ck_lvl = (agree & ck_s3) | (~agree & r.ck_lvl);
      next_r.wr_commit = 1'b0;

      // Primary strobe rise: write request, first beat and read request.
      if (k_rise)
      begin
         next_r.wr_go     = ~r.s3[P_WR];
         next_r.wd0       = r.s3[DATA_W-1:0];
         next_r.wm0       = r.s3[P_M +: LANES];
         next_r.rd_armed  = r.rd_pend;
         next_r.rloc      = r.rloc_pend;
         next_r.rd_pend   = ~r.s3[P_RD];
         next_r.rloc_pend = r.s3[P_L +: LOC_W];
      end

      // Complement strobe rise: location, second beat, then store.
      if (kn_rise)
      begin
         next_r.wloc      = r.s3[P_L +: LOC_W];
         next_r.wd1       = r.s3[DATA_W-1:0];
         next_r.wm1       = r.s3[P_M +: LANES];
         next_r.wr_commit = r.wr_go;
         next_r.wr_go     = 1'b0;
      end

      // Returned strobes follow the firing clocks whatever the ports do.
      next_r.ros   = fire_lvl;
      next_r.ros_n = firen_lvl;
      if (fire_lvl & ~r.ros)
      begin
         next_r.q_oe   = r.rd_armed;
         next_r.q      = mem[{r.rloc, sram_link_pkg::BEAT0}];
         next_r.q_hold = mem[{r.rloc, sram_link_pkg::BEAT1}];
      end
      if (firen_lvl & ~r.ros_n & r.q_oe)
      begin
         next_r.q = r.q_hold;
      end

      // Startup count runs regardless of selection.
      if (!r.ready)
      begin
         next_r.start_cnt = r.start_cnt + 1'b1;
         next_r.ready     = (r.start_cnt == CNT_W'(CAL_START - 1));
      end

      // Periodic evaluation, then the counter starts again.
      if (r.cal_cnt == CNT_W'(CAL_PERIOD - 1))
      begin
         next_r.cal_cnt = '0;
         next_r.pd_pend = 1'b1;
         next_r.pu_pend = 1'b1;
      end
      else
      begin
         next_r.cal_cnt = r.cal_cnt + 1'b1;
      end

      // Each leg steps only while the pins drive the opposite level or float.
      if (r.pd_pend & (~r.q_oe | (&r.q)))
      begin
         next_r.pd      = step_toward(r.pd, impedance_set_pin);
         next_r.pd_pend = (r.cal_cnt == CNT_W'(CAL_PERIOD - 1)); // A fresh evaluation wins over the clear.
      end
      if (r.pu_pend & (~r.q_oe | ~(|r.q)))
      begin
         next_r.pu      = step_toward(r.pu, impedance_set_pin);
         next_r.pu_pend = (r.cal_cnt == CNT_W'(CAL_PERIOD - 1)); // A fresh evaluation wins over the clear.
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         r    <= '0;
         r.pd <= sram_link_pkg::IMP_RESET;
         r.pu <= sram_link_pkg::IMP_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Array store: both beats of a burst, masked lanes left as they were.
   always_ff @(posedge clk)
   begin
      if (r.wr_commit)
      begin
         mem[{r.wloc, sram_link_pkg::BEAT0}] <= (mem[{r.wloc, sram_link_pkg::BEAT0}] & ~lane_en(r.wm0))
                                             | (r.wd0 & lane_en(r.wm0));
         mem[{r.wloc, sram_link_pkg::BEAT1}] <= (mem[{r.wloc, sram_link_pkg::BEAT1}] & ~lane_en(r.wm1))
                                             | (r.wd1 & lane_en(r.wm1));
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign link.q                        = r.q;
   assign link.q_oe                     = r.q_oe;
   assign link.returned_output_strobe   = r.ros;
   assign link.returned_output_strobe_n = r.ros_n;
   assign pd_code                       = r.pd;
   assign pu_code                       = r.pu;
   assign imped_ready                   = r.ready;
endmodule : sram_port_device

/* File: sram_port_host.sv */
// Controller end of the link: strobe divider, command driving and read capture.
`timescale 1ns/1ps
module sram_port_host #(
   parameter int DATA_W    = sram_link_pkg::DATA_W,
   parameter int LOC_W     = sram_link_pkg::LOC_W,
   parameter int CAL_START = sram_link_pkg::CAL_START_CYCLES,
   parameter bit TIE_C     = 1'b1
)(
   input  wire logic                   clk,
   input  wire logic                   nrst,
   sram_link_if.host                   link,
   input  wire logic                   wr_valid,
   output logic                        wr_ready,
   input  wire logic [LOC_W-1:0]       wr_loc,
   input  wire logic [2*DATA_W-1:0]    wr_data,
   input  wire logic [2*(DATA_W/9)-1:0] wr_mask_n,
   input  wire logic                   rd_valid,
   output logic                        rd_ready,
   input  wire logic [LOC_W-1:0]       rd_loc,
   output logic                        rd_data_valid,
   input  wire logic                   rd_data_ready,
   output logic [2*DATA_W-1:0]         rd_data
);
   localparam int LANES = DATA_W / sram_link_pkg::LANE_W;
   localparam int SW    = DATA_W + 2;
   localparam int CNT_W = $clog2(CAL_START + 1);

   typedef struct packed {
      logic [2:0]                ph;
      logic                      k;
      logic                      k_n;
      logic                      c;
      logic                      c_n;
      logic [CNT_W-1:0]          start_cnt;
      logic                      started;
      logic                      wr_n;
      logic                      rd_n;
      logic [LOC_W-1:0]          loc;
      logic [DATA_W-1:0]         d;
      logic [LANES-1:0]          mask;
      logic [LOC_W-1:0]          wloc1;
      logic [DATA_W-1:0]         d1;
      logic [LANES-1:0]          m1;
      logic [SW-1:0]             s1;
      logic [SW-1:0]             s2;
      logic [SW-1:0]             s3;
      logic [1:0]                st_lvl;
      sram_link_pkg::rd_state_e  rd_st;
      logic [DATA_W-1:0]         cap0;
      logic                      push;
      logic [2*DATA_W-1:0]       word;
   } host_s;

   host_s      r;
   host_s      next_r;
   logic       buf_ready;
   logic       wr_take;
   logic       rd_take;
   logic [1:0] agree;
   logic [1:0] st_rise;

   // Commands are taken once per link cycle, after the startup wait.
   assign wr_ready = r.started & (r.ph == sram_link_pkg::PH_CMD);
   assign rd_ready = wr_ready & (r.rd_st == sram_link_pkg::RD_IDLE) & buf_ready;
   assign wr_take  = wr_valid & wr_ready;
   assign rd_take  = rd_valid & rd_ready;
   // Returned strobe edges count once the last two sampler stages agree.
   assign agree    = ~(r.s2[SW-1 -: 2] ^ r.s3[SW-1 -: 2]);
   assign st_rise  = agree & r.s3[SW-1 -: 2] & ~r.st_lvl;

   always_comb
   begin
      next_r       = r;
      next_r.ph    = r.ph + 1'b1;
      next_r.k     = (next_r.ph < 3'(sram_link_pkg::K_HALF_CYCLES));
      next_r.k_n   = ~next_r.k;
      next_r.c     = TIE_C | r.k;                  // Tied high hands firing to the input strobes.
      next_r.c_n   = TIE_C | r.k_n;
      next_r.s1    = {link.returned_output_strobe, link.returned_output_strobe_n, link.q};
      next_r.s2    = r.s1;
      next_r.s3    = r.s2;
      next_r.st_lvl = (agree & r.s3[SW-1 -: 2]) | (~agree & r.st_lvl);
      next_r.push  = 1'b0;
      if (!r.started)
      begin
         next_r.start_cnt = r.start_cnt + 1'b1;
         next_r.started   = (r.start_cnt == CNT_W'(CAL_START - 1));
      end

      // Request, read location and first beat set up ahead of the primary rise.
      if (r.ph == sram_link_pkg::PH_CMD)
      begin
         next_r.wr_n  = ~wr_take;
         next_r.rd_n  = ~rd_take;
         next_r.loc   = rd_loc;
         next_r.d     = wr_data[DATA_W-1:0];
         next_r.mask  = wr_take ? wr_mask_n[LANES-1:0] : '1;
         next_r.wloc1 = wr_loc;
         next_r.d1    = wr_data[2*DATA_W-1:DATA_W];
         next_r.m1    = wr_take ? wr_mask_n[2*LANES-1:LANES] : '1;
      end
      // Write location and second beat set up ahead of the complement rise.
      if (r.ph == sram_link_pkg::PH_BEAT1)
      begin
         next_r.loc  = r.wloc1;
         next_r.d    = r.d1;
         next_r.mask = r.m1;
      end

      // Read return: arm mid-cycle after the answering edge, catch two beats.
      case (r.rd_st)
         sram_link_pkg::RD_IDLE:
         begin
            if (rd_take)
            begin
               next_r.rd_st = sram_link_pkg::RD_SENT;
            end
         end
         sram_link_pkg::RD_SENT:
         begin
            if (r.ph == sram_link_pkg::PH_ARM)
            begin
               next_r.rd_st = sram_link_pkg::RD_WAIT;
            end
         end
         sram_link_pkg::RD_WAIT:
         begin
            if (r.ph == sram_link_pkg::PH_ARM)
            begin
               next_r.rd_st = sram_link_pkg::RD_ARMED;
            end
         end
         sram_link_pkg::RD_ARMED:
         begin
            if (st_rise[1])
            begin
               next_r.cap0  = r.s3[DATA_W-1:0];
               next_r.rd_st = sram_link_pkg::RD_BEAT1;
            end
         end
         sram_link_pkg::RD_BEAT1:
         begin
            if (st_rise[0])
            begin
               next_r.word  = {r.s3[DATA_W-1:0], r.cap0};
               next_r.push  = 1'b1;
               next_r.rd_st = sram_link_pkg::RD_IDLE;
            end
         end
         default:
         begin
            next_r.rd_st = sram_link_pkg::RD_IDLE;
         end
      endcase
   end

   // State register with synchronous reset; strobe divider starts at zero.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         r       <= '0;
         r.wr_n  <= 1'b1;
         r.rd_n  <= 1'b1;
         r.mask  <= '1;
         r.c     <= 1'b1;
         r.c_n   <= 1'b1;
         r.rd_st <= sram_link_pkg::RD_IDLE;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Returned words wait here so a stalled consumer loses nothing.
   pair_buffer #(
      .W     (2*DATA_W),
      .DEPTH (2)
   ) u_buf (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (r.push),
      .in_ready  (buf_ready),
      .in_data   (r.word),
      .out_valid (rd_data_valid),
      .out_ready (rd_data_ready),
      .out_data  (rd_data)
   );

   assign link.k               = r.k;
   assign link.k_n             = r.k_n;
   assign link.c               = r.c;
   assign link.c_n             = r.c_n;
   assign link.store_request_n = r.wr_n;
   assign link.fetch_enable_n  = r.rd_n;
   assign link.location_inputs = r.loc;
   assign link.lane_mask_n     = r.mask;
   assign link.d               = r.d;
endmodule : sram_port_host

/* File: ddr_burst2_sram_port_monitor.sv */
// Concurrent checks on the link pins between the controller and the SRAM port.
`timescale 1ns/1ps
module ddr_burst2_sram_port_monitor #(
   parameter int DATA_W = sram_link_pkg::DATA_W
)(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              k,
   input wire logic              fetch_enable_n,
   input wire logic [DATA_W-1:0] q,
   input wire logic              q_oe,
   input wire logic              returned_output_strobe,
   input wire logic              returned_output_strobe_n
);
   // -------------------------------------------------------------
   // Link checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic [4:0] still;
   // Counts cycles since the true returned strobe last moved.
   always_ff @(posedge clk)
      still <= (!nrst || $changed(returned_output_strobe)) ? 5'h0 : still + 5'h1;
   property p_pair; $rose(returned_output_strobe) |-> !returned_output_strobe_n; endproperty
   a_pair: assert property (p_pair) else $error("strobes not inverted");
   property p_runs; still < 5'h10; endproperty
   a_runs: assert property (p_runs) else $error("returned strobe stopped");
   property p_move; $changed(q) |-> $changed(returned_output_strobe); endproperty
   a_move: assert property (p_move) else $error("data moved without strobe");
   property p_on; $rose(q_oe) |-> $rose(returned_output_strobe); endproperty
   a_on: assert property (p_on) else $error("drive began off strobe rise");
   property p_off; $fell(q_oe) |-> $rose(returned_output_strobe); endproperty
   a_off: assert property (p_off) else $error("drive ended off strobe rise");
   property p_lat; $rose(k) && !fetch_enable_n |-> ##[8:20] q_oe; endproperty
   a_lat: assert property (p_lat) else $error("read data missing");
   property p_desel; $rose(k) && fetch_enable_n |-> ##[8:20] !q_oe; endproperty
   a_desel: assert property (p_desel) else $error("deselect still driving");
   property p_fire; $rose(k) |-> ##[2:8] $rose(returned_output_strobe); endproperty
   a_fire: assert property (p_fire) else $error("strobe not following input strobe");
endmodule : ddr_burst2_sram_port_monitor

/* File: ddr_burst2_sram_port_bench.sv */
// Self-checking bench for the controller and SRAM port joined over the link.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t got %h", $time, a); end end
module ddr_burst2_sram_port_bench;
   localparam logic [35:0] D0 = 36'h1_2345_6789;
   localparam logic [35:0] N  = 36'hf_edcb_a987;
   logic        clk = 1'b0;
   logic        nrst, wr_valid, wr_ready, rd_valid, rd_ready, rd_data_valid, rd_data_ready, imped_ready;
   logic [7:0]  wr_loc, rd_loc;
   logic [35:0] wr_data, rd_data;
   logic [3:0]  wr_mask_n;
   logic [4:0]  imp_want, pd_code, pu_code;
   logic        wr_ready_alt, rd_ready_alt, rd_data_valid_alt;
   logic [35:0] rd_data_alt;
   int          num_errors, n_checks;
   sram_link_if sram_link_if_i ();
   sram_port_host #(.CAL_START(64)) sram_port_host_i (.clk(clk), .nrst(nrst), .link(sram_link_if_i.host),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_loc(wr_loc), .wr_data(wr_data), .wr_mask_n(wr_mask_n),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_loc(rd_loc), .rd_data_valid(rd_data_valid),
      .rd_data_ready(rd_data_ready), .rd_data(rd_data));
   sram_port_device #(.CAL_START(64), .CAL_PERIOD(16)) sram_port_device_i (.clk(clk), .nrst(nrst),
      .link(sram_link_if_i.device), .impedance_set_pin(imp_want), .pd_code(pd_code), .pu_code(pu_code),
      .imped_ready(imped_ready));
   ddr_burst2_sram_port_monitor ddr_burst2_sram_port_monitor_i (.clk(clk), .nrst(nrst), .k(sram_link_if_i.k),
      .fetch_enable_n(sram_link_if_i.fetch_enable_n), .q(sram_link_if_i.q), .q_oe(sram_link_if_i.q_oe),
      .returned_output_strobe(sram_link_if_i.returned_output_strobe),
      .returned_output_strobe_n(sram_link_if_i.returned_output_strobe_n));
   // Second pair with live output clocks, so the device fires its outputs from them.
   sram_link_if sram_link_if_alt_i ();
   sram_port_host #(.CAL_START(64), .TIE_C(1'b0)) sram_port_host_alt_i (.clk(clk), .nrst(nrst),
      .link(sram_link_if_alt_i.host), .wr_valid(wr_valid), .wr_ready(wr_ready_alt), .wr_loc(wr_loc),
      .wr_data(wr_data), .wr_mask_n(wr_mask_n), .rd_valid(rd_valid), .rd_ready(rd_ready_alt), .rd_loc(rd_loc),
      .rd_data_valid(rd_data_valid_alt), .rd_data_ready(rd_data_ready), .rd_data(rd_data_alt));
   sram_port_device #(.CAL_START(64), .CAL_PERIOD(16)) sram_port_device_alt_i (.clk(clk), .nrst(nrst),
      .link(sram_link_if_alt_i.device), .impedance_set_pin(imp_want), .pd_code(), .pu_code(),
      .imped_ready());
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   always #10 clk = ~clk;
   // Prints the counts and the verdict, then ends the run.
   task final_report;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   // Offers a write and/or read at one location, then checks the returned pair.
   task automatic xfer(input bit w, input bit r, input logic [7:0] loc, input logic [35:0] data,
                       input logic [3:0] mask, input logic [35:0] want);
      int i;
      wr_valid = w;
      rd_valid = r;
      wr_loc = loc;
      rd_loc = loc;
      wr_data = data;
      wr_mask_n = mask;
      for (i = 0; i < 400 && !((!w || (wr_ready & wr_ready_alt) === 1'b1)
                               && (!r || (rd_ready & rd_ready_alt) === 1'b1)); i++)
         @(negedge clk);
      if (i == 400)
      begin
         num_errors++;
         $display("ERROR %0t request not taken", $time);
      end
      @(negedge clk);
      wr_valid = 1'b0;
      rd_valid = 1'b0;
      @(negedge clk);
      if (r)
      begin
         for (i = 0; i < 100 && (rd_data_valid & rd_data_valid_alt) !== 1'b1; i++)
            @(negedge clk);
         `CHK(rd_data_valid, 1'b1)
         `CHK(rd_data, want)
         `CHK(rd_data_valid_alt, 1'b1)
         `CHK(rd_data_alt, want)
         rd_data_ready = 1'b1;
         @(negedge clk);
         rd_data_ready = 1'b0;
      end
   endtask : xfer
   // Main sequence, driven on falling edges.
   initial
   begin
      nrst = 1'b0;
      wr_valid = 1'b0;
      rd_valid = 1'b0;
      rd_data_ready = 1'b0;
      wr_loc = 8'h00;
      rd_loc = 8'h00;
      wr_data = '0;
      wr_mask_n = 4'hf;
      imp_want = 5'h12;
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      `CHK(pd_code, 5'h10)
      `CHK(imped_ready, 1'b0)
      repeat (23) @(negedge clk);
      `CHK(pd_code, 5'h11)
      repeat (50) @(negedge clk);
      `CHK(imped_ready, 1'b1)
      `CHK(pd_code, 5'h12)
      `CHK(pu_code, 5'h12)
      xfer(1'b1, 1'b0, 8'h03, D0, 4'h0, '0);
      xfer(1'b0, 1'b1, 8'h03, '0, 4'hf, D0);
      xfer(1'b1, 1'b0, 8'h03, N, 4'h6, '0);
      xfer(1'b0, 1'b1, 8'h03, '0, 4'hf, {N[35:27], D0[26:9], N[8:0]});
      xfer(1'b1, 1'b0, 8'h03, 36'h0, 4'hf, '0);
      xfer(1'b0, 1'b1, 8'h03, '0, 4'hf, {N[35:27], D0[26:9], N[8:0]});
      repeat (40) @(negedge clk);
      xfer(1'b1, 1'b1, 8'h05, N, 4'h0, N);
      final_report();
   end
   // Cuts a hung run short.
   initial
   begin
      num_errors = 0;
      n_checks = 0;
      repeat (3000) @(posedge clk);
      num_errors++;
      final_report();
   end
endmodule : ddr_burst2_sram_port_bench
